// ### rtl/xdec_pkg.sv
package xdec_pkg;

    // Widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int PC_W   = 21;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;

    // Register byte offsets
    localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [REG_AW-1:0] REG_BANK   = 8'h04;
    localparam logic [REG_AW-1:0] REG_PTR0   = 8'h08;
    localparam logic [REG_AW-1:0] REG_PTR1   = 8'h0c;
    localparam logic [REG_AW-1:0] REG_PTR2   = 8'h10;
    localparam logic [REG_AW-1:0] REG_STACK  = 8'h14;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h18;

    // Field positions and reset values
    localparam int                CTRL_EXT_BIT   = 0;
    localparam logic              CTRL_EXT_RESET = 1'b1;
    localparam logic [3:0]        BANK_RESET     = 4'h0;
    localparam logic [ADDR_W-1:0] PTR_RESET      = 12'h000;
    localparam logic [PC_W-1:0]   STACK_RESET    = 21'h000000;

    // Opcode fields
    localparam logic [8:0] OP_MOVE_FIRST  = 9'h1d7;
    localparam logic [3:0] OP_SECOND_WORD = 4'hf;
    localparam logic [7:0] OP_PUSH_LIT    = 8'hfa;
    localparam logic [7:0] OP_SUB_PTR     = 8'he9;
    localparam logic [1:0] SEL_RETURN     = 2'b11;
    localparam logic [1:0] SEL_FRAME      = 2'b10;

    // Data space map
    localparam logic [7:0]        OFFSET_LIMIT = 8'h5f;
    localparam logic [3:0]        SFR_BANK     = 4'hf;
    localparam logic [ADDR_W-1:0] INDIRECT_LO  = 12'hfe0;
    localparam logic [ADDR_W-1:0] INDIRECT_HI  = 12'hfef;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_WORD2   = 3'b001,
        ST_READ    = 3'b010,
        ST_WRITE   = 3'b011,
        ST_RET_NOP = 3'b100
    } state_t;

    // Sum wraps at the data space width
    function automatic logic [ADDR_W-1:0] add_offset(input logic [ADDR_W-1:0] base,
                                                      input logic [7:0]        off);
        return base + {4'h0, off};
    endfunction

    function automatic logic is_indirect(input logic [ADDR_W-1:0] addr);
        return (addr >= INDIRECT_LO) && (addr <= INDIRECT_HI);
    endfunction

    function automatic logic [ADDR_W-1:0] ptr_pick(input logic [ADDR_W-1:0] p0,
                                                    input logic [ADDR_W-1:0] p1,
                                                    input logic [ADDR_W-1:0] p2,
                                                    input logic [1:0]        sel);
        case (sel)
            2'b00:   return p0;
            2'b01:   return p1;
            default: return p2;
        endcase
    endfunction

endpackage

// ### rtl/pointer_file.sv
`timescale 1ns/1ns
module pointer_file (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       sw_we,
    input  wire logic [1:0]                 sw_sel,
    input  wire logic [xdec_pkg::ADDR_W-1:0] sw_data,
    input  wire logic                       hw_we,
    input  wire logic [1:0]                 hw_sel,
    input  wire logic [xdec_pkg::ADDR_W-1:0] hw_data,
    output logic      [xdec_pkg::ADDR_W-1:0] ptr0,
    output logic      [xdec_pkg::ADDR_W-1:0] ptr1,
    output logic      [xdec_pkg::ADDR_W-1:0] ptr2
);
    import xdec_pkg::*;

    logic [ADDR_W-1:0] ptr_q [3];

    // Instruction update wins over a same-cycle software write
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 3; i++) begin
                ptr_q[i] <= PTR_RESET;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (hw_we && hw_sel == 2'(i)) begin
                    ptr_q[i] <= hw_data;
                end else if (sw_we && sw_sel == 2'(i)) begin
                    ptr_q[i] <= sw_data;
                end
            end
        end
    end

    assign ptr0 = ptr_q[0];
    assign ptr1 = ptr_q[1];
    assign ptr2 = ptr_q[2];

endmodule

// ### rtl/file_addr_resolve.sv
`timescale 1ns/1ns
module file_addr_resolve (
    input  wire logic                        ext_en,
    input  wire logic                        a_bit,
    input  wire logic [7:0]                  f_operand,
    input  wire logic [xdec_pkg::ADDR_W-1:0] frame_pointer,
    input  wire logic [3:0]                  bank_select,
    output logic      [xdec_pkg::ADDR_W-1:0] addr,
    output logic                             offset_mode
);
    import xdec_pkg::*;

    always_comb begin
        offset_mode = ext_en && !a_bit && (f_operand <= OFFSET_LIMIT);
        if (offset_mode) begin
            addr = add_offset(frame_pointer, f_operand);
        end else if (a_bit) begin
            addr = {bank_select, f_operand};
        end else if (f_operand <= OFFSET_LIMIT) begin
            addr = {4'h0, f_operand};
        end else begin
            addr = {SFR_BANK, f_operand};
        end
    end

endmodule

// ### rtl/extended_stack_instruction_decode.sv
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
// What this block does
// - Indexed move forms source and destination as frame pointer plus 7-bit offsets.
// - Move endpoints may be anywhere in the 4096-byte data space.
// - Move source on an indirect register reads as zero.
// - Move destination on an indirect register makes the move a no-op.
// - Push-literal writes its 8-bit immediate at the frame pointer address.
// - Push-literal then decrements the frame pointer by one.
// - Subtract-from-pointer is an 8-bit prefix, 2-bit select, 6-bit literal.
// - Subtract-from-pointer subtracts the literal from pointer 0, 1 or 2.
// - Select value 11 means subtract-and-return on the frame pointer.
// - Subtract-and-return then loads the program counter from stack top.
// - Subtract-and-return takes two cycles, the second doing nothing.
// - Extension on, a=0, operand up to 5Fh: offset from frame pointer.
// - Extension off: access bank for a=0, selected bank for a=1.
// - Reinterpretation applies to all byte and bit instructions with access bit.
// - Frame pointer zero gives the plain access bank addresses.
// - Destination bit keeps its meaning in offset mode.
// - Offset operands treat the access bit as zero.
// - Extension works only while its enable bit is one.
module extended_stack_instruction_decode (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        instr_valid,
    input  wire logic [xdec_pkg::WORD_W-1:0] instr_word,
    output logic                             instr_ready_q,
    input  wire logic [xdec_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [xdec_pkg::REG_DW-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [xdec_pkg::REG_DW-1:0] reg_rdata_q,
    output logic                             mem_rd_en_q,
    output logic      [xdec_pkg::ADDR_W-1:0] mem_rd_addr_q,
    input  wire logic [xdec_pkg::DATA_W-1:0] mem_rdata,
    output logic                             mem_wr_en_q,
    output logic      [xdec_pkg::ADDR_W-1:0] mem_wr_addr_q,
    output logic      [xdec_pkg::DATA_W-1:0] mem_wdata_q,
    output logic                             pc_load_q,
    output logic      [xdec_pkg::PC_W-1:0]   pc_value_q,
    output logic                             eff_valid_q,
    output logic      [xdec_pkg::ADDR_W-1:0] eff_addr_q,
    output logic                             eff_offset_q,
    output logic                             eff_to_file_q
);
    import xdec_pkg::*;

    state_t            state_q;
    state_t            state_d;
    logic              ext_en_q;
    logic [3:0]        bank_q;
    logic [PC_W-1:0]   stack_top_q;
    logic [ADDR_W-1:0] indirect_pointer0;
    logic [ADDR_W-1:0] indirect_pointer1;
    logic [ADDR_W-1:0] frame_pointer;
    logic [ADDR_W-1:0] src_q;
    logic [ADDR_W-1:0] dst_q;
    logic              src_ind_q;
    logic              dst_ind_q;
    logic              take;
    logic              is_move1;
    logic              is_push_lit;
    logic              is_sub_ptr;
    logic              is_return;
    logic              is_access;
    logic              is_byte_op;
    logic [1:0]        sub_sel;
    logic [7:0]        sub_lit;
    logic [ADDR_W-1:0] sub_target;
    logic              hw_we;
    logic [1:0]        hw_sel;
    logic [ADDR_W-1:0] hw_data;
    logic              sw_ptr_we;
    logic [1:0]        sw_ptr_sel;
    logic [ADDR_W-1:0] res_addr;
    logic              res_offset;
    logic [ADDR_W-1:0] move_src;
    logic [ADDR_W-1:0] move_dst;

    // Only first words are decoded in idle; the word after a move's first is its second
    assign take       = instr_valid && instr_ready_q;
    assign is_move1    = ext_en_q && instr_word[15:7] == OP_MOVE_FIRST;
    assign is_push_lit = ext_en_q && instr_word[15:8] == OP_PUSH_LIT;
    assign is_sub_ptr  = ext_en_q && instr_word[15:8] == OP_SUB_PTR;
    assign sub_sel    = instr_word[7:6];
    assign sub_lit    = {2'b00, instr_word[5:0]};
    assign is_return  = is_sub_ptr && sub_sel == SEL_RETURN;
    assign is_byte_op = instr_word[15:10] == 6'b000001 || instr_word[15:9] == 7'b0000001
                        || (instr_word[15:12] >= 4'h1 && instr_word[15:12] <= 4'h6);
    assign is_access  = is_byte_op
                        || (instr_word[15:12] >= 4'h7 && instr_word[15:12] <= 4'hb);

    assign move_src   = add_offset(frame_pointer, {1'b0, instr_word[6:0]});
    assign move_dst   = add_offset(frame_pointer, {1'b0, instr_word[6:0]});
    assign sub_target = ptr_pick(indirect_pointer0, indirect_pointer1, frame_pointer,
                                 is_return ? SEL_FRAME : sub_sel);

    file_addr_resolve u_resolve (
        .ext_en        (ext_en_q),
        .a_bit         (instr_word[8]),
        .f_operand     (instr_word[7:0]),
        .frame_pointer (frame_pointer),
        .bank_select   (bank_q),
        .addr          (res_addr),
        .offset_mode   (res_offset)
    );

    // Pointer updates from instructions
    always_comb begin
        hw_we   = 1'b0;
        hw_sel  = SEL_FRAME;
        hw_data = frame_pointer;
        if (take && state_q == ST_IDLE) begin
            if (is_push_lit) begin
                hw_we   = 1'b1;
                hw_data = frame_pointer - 12'h001;
            end else if (is_sub_ptr) begin
                hw_we   = 1'b1;
                hw_sel  = is_return ? SEL_FRAME : sub_sel;
                hw_data = sub_target - {4'h0, sub_lit};
            end
        end
    end

    assign sw_ptr_we  = reg_wr && (reg_addr == REG_PTR0 || reg_addr == REG_PTR1
                                   || reg_addr == REG_PTR2);
    assign sw_ptr_sel = reg_addr[3:2] - 2'b10;

    pointer_file u_ptrs (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .sw_we   (sw_ptr_we),
        .sw_sel  (sw_ptr_sel),
        .sw_data (reg_wdata[ADDR_W-1:0]),
        .hw_we   (hw_we),
        .hw_sel  (hw_sel),
        .hw_data (hw_data),
        .ptr0    (indirect_pointer0),
        .ptr1    (indirect_pointer1),
        .ptr2    (frame_pointer)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take && is_move1) begin
                    state_d = ST_WORD2;
                end else if (take && is_return) begin
                    state_d = ST_RET_NOP;
                end
            end
            ST_WORD2: begin
                if (take) begin
                    state_d = ST_READ;
                end
            end
            ST_READ:    state_d = ST_WRITE;
            ST_WRITE:   state_d = ST_IDLE;
            ST_RET_NOP: state_d = ST_IDLE;
            default:    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q       <= ST_IDLE;
            instr_ready_q <= 1'b0;
        end else begin
            state_q       <= state_d;
            instr_ready_q <= state_d == ST_IDLE || state_d == ST_WORD2;
        end
    end

    // Move addresses captured per word
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            src_q     <= PTR_RESET;
            dst_q     <= PTR_RESET;
            src_ind_q <= 1'b0;
            dst_ind_q <= 1'b0;
        end else if (take && state_q == ST_IDLE && is_move1) begin
            src_q     <= move_src;
            src_ind_q <= is_indirect(move_src);
        end else if (take && state_q == ST_WORD2) begin
            dst_q     <= move_dst;
            dst_ind_q <= is_indirect(move_dst);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mem_rd_en_q   <= 1'b0;
            mem_rd_addr_q <= PTR_RESET;
        end else begin
            mem_rd_en_q <= take && state_q == ST_WORD2 && !src_ind_q && !is_indirect(move_dst);
            if (take && state_q == ST_WORD2) begin
                mem_rd_addr_q <= src_q;
            end
        end
    end

    // Memory write path
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mem_wr_en_q   <= 1'b0;
            mem_wr_addr_q <= PTR_RESET;
            mem_wdata_q   <= 8'h00;
        end else begin
            mem_wr_en_q <= 1'b0;
            if (take && state_q == ST_IDLE && is_push_lit) begin
                mem_wr_en_q   <= 1'b1;
                mem_wr_addr_q <= frame_pointer;
                mem_wdata_q   <= instr_word[7:0];
            end else if (state_q == ST_WRITE) begin
                mem_wr_en_q   <= !dst_ind_q;
                mem_wr_addr_q <= dst_q;
                mem_wdata_q   <= src_ind_q ? 8'h00 : mem_rdata;
            end
        end
    end

    // Return path
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pc_load_q  <= 1'b0;
            pc_value_q <= STACK_RESET;
        end else begin
            pc_load_q <= take && state_q == ST_IDLE && is_return;
            if (take && state_q == ST_IDLE && is_return) begin
                pc_value_q <= stack_top_q;
            end
        end
    end

    // Resolved operand for standard byte and bit instructions
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            eff_valid_q   <= 1'b0;
            eff_addr_q    <= PTR_RESET;
            eff_offset_q  <= 1'b0;
            eff_to_file_q <= 1'b0;
        end else begin
            eff_valid_q <= take && state_q == ST_IDLE && is_access;
            if (take && state_q == ST_IDLE && is_access) begin
                eff_addr_q    <= res_addr;
                eff_offset_q  <= res_offset;
                eff_to_file_q <= is_byte_op ? instr_word[9] : 1'b1;
            end
        end
    end

    // Software registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ext_en_q    <= CTRL_EXT_RESET;
            bank_q      <= BANK_RESET;
            stack_top_q <= STACK_RESET;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ext_en_q <= reg_wdata[CTRL_EXT_BIT];
            end
            if (reg_addr == REG_BANK) begin
                bank_q <= reg_wdata[3:0];
            end
            if (reg_addr == REG_STACK) begin
                stack_top_q <= reg_wdata[PC_W-1:0];
            end
        end
    end

    // Read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:   reg_rdata_q <= {31'h00000000, ext_en_q};
                REG_BANK:   reg_rdata_q <= {28'h0000000, bank_q};
                REG_PTR0:   reg_rdata_q <= {20'h00000, indirect_pointer0};
                REG_PTR1:   reg_rdata_q <= {20'h00000, indirect_pointer1};
                REG_PTR2:   reg_rdata_q <= {20'h00000, frame_pointer};
                REG_STACK:  reg_rdata_q <= {11'h000, stack_top_q};
                REG_STATUS: reg_rdata_q <= {28'h0000000, state_q, instr_ready_q};
                default:    reg_rdata_q <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_return_taken;
        take && state_q == ST_IDLE && is_return;
    endsequence
    sequence s_quiet_slot;
        !instr_ready_q && !mem_wr_en_q && !mem_rd_en_q;
    endsequence
    sequence s_move_write;
        state_q == ST_WRITE;
    endsequence

    property p_push_store;
        take && state_q == ST_IDLE && is_push_lit |=> mem_wr_en_q
            && mem_wr_addr_q == $past(frame_pointer) && mem_wdata_q == $past(instr_word[7:0]);
    endproperty
    a_push_store: assert property (p_push_store) else $error("push literal store wrong");
    property p_push_dec;
        take && state_q == ST_IDLE && is_push_lit |=>
            frame_pointer == $past(frame_pointer) - 12'h001;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("frame not decremented");
    property p_sub_ptr;
        take && state_q == ST_IDLE && is_sub_ptr && !is_return |=>
            ptr_pick(indirect_pointer0, indirect_pointer1, frame_pointer, $past(sub_sel))
            == $past(sub_target) - {4'h0, $past(sub_lit)};
    endproperty
    a_sub_ptr: assert property (p_sub_ptr) else $error("pointer subtract wrong");
    property p_return_load;
        s_return_taken |=> pc_load_q && pc_value_q == $past(stack_top_q)
            && frame_pointer == $past(frame_pointer) - {4'h0, $past(sub_lit)};
    endproperty
    a_return_load: assert property (p_return_load) else $error("return load wrong");
    property p_return_nop;
        s_return_taken |=> s_quiet_slot ##1 (instr_ready_q && !pc_load_q);
    endproperty
    a_return_nop: assert property (p_return_nop) else $error("return second cycle busy");
    property p_move_src;
        take && state_q == ST_IDLE && is_move1 ##1 take |=>
            mem_rd_en_q == (!src_ind_q && !dst_ind_q)
            && mem_rd_addr_q == $past(src_q) ##1 s_move_write;
    endproperty
    a_move_src: assert property (p_move_src) else $error("move source wrong");
    property p_move_zero;
        s_move_write and src_ind_q && !dst_ind_q |=> mem_wr_en_q && mem_wdata_q == 8'h00;
    endproperty
    a_move_zero: assert property (p_move_zero) else $error("indirect source not zero");
    property p_move_nop;
        s_move_write and dst_ind_q |=> !mem_wr_en_q;
    endproperty
    a_move_nop: assert property (p_move_nop) else $error("indirect destination written");
    property p_offset_mode;
        take && state_q == ST_IDLE && is_access && ext_en_q && !instr_word[8]
            && instr_word[7:0] <= OFFSET_LIMIT |=> eff_valid_q && eff_offset_q
            && eff_addr_q == add_offset($past(frame_pointer), $past(instr_word[7:0]));
    endproperty
    a_offset_mode: assert property (p_offset_mode) else $error("offset operand wrong");
    property p_banked;
        take && state_q == ST_IDLE && is_access && !ext_en_q && instr_word[8] |=>
            !eff_offset_q && eff_addr_q == {$past(bank_q), $past(instr_word[7:0])};
    endproperty
    a_banked: assert property (p_banked) else $error("banked operand wrong");

endmodule

// ### bench/extended_stack_instruction_decode_test.sv
`timescale 1ns/1ns
`define chk(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module extended_stack_instruction_decode_test;
    import xdec_pkg::*;
    logic              sys_clk     = 1'b0;
    logic              sys_rst     = 1'b1;
    logic              instr_valid = 1'b0;
    logic [WORD_W-1:0] instr_word  = 16'h0000;
    logic [REG_AW-1:0] reg_addr    = 8'h00;
    logic [REG_DW-1:0] reg_wdata   = 32'h0;
    logic              reg_wr      = 1'b0;
    logic              reg_rd      = 1'b0;
    logic [DATA_W-1:0] mem_rdata   = 8'h00;
    logic [DATA_W-1:0] src_val     = 8'h00;
    logic              instr_ready_q, mem_rd_en_q, mem_wr_en_q, pc_load_q;
    logic              eff_valid_q, eff_offset_q, eff_to_file_q;
    logic [REG_DW-1:0] reg_rdata_q;
    logic [ADDR_W-1:0] mem_rd_addr_q, mem_wr_addr_q, eff_addr_q;
    logic [DATA_W-1:0] mem_wdata_q;
    logic [PC_W-1:0]   pc_value_q;
    int                failures = 0;
    int                n_checks = 0;

    extended_stack_instruction_decode i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready_q(instr_ready_q), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .mem_rd_en_q(mem_rd_en_q), .mem_rd_addr_q(mem_rd_addr_q), .mem_rdata(mem_rdata),
        .mem_wr_en_q(mem_wr_en_q), .mem_wr_addr_q(mem_wr_addr_q), .mem_wdata_q(mem_wdata_q),
        .pc_load_q(pc_load_q), .pc_value_q(pc_value_q), .eff_valid_q(eff_valid_q),
        .eff_addr_q(eff_addr_q), .eff_offset_q(eff_offset_q), .eff_to_file_q(eff_to_file_q)
    );

    always #50 sys_clk = ~sys_clk;

    // Unread cycles show a changing pattern, never stale data
    always @(posedge sys_clk) begin
        mem_rdata <= mem_rd_en_q ? src_val : ~mem_rdata;
    end

    task automatic complete_run();
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        `chk(reg_rdata_q, e)
    endtask

    // Holds the word until taken; bounded so a stuck ready ends the run
    task automatic send(input logic [15:0] w, input logic last);
        int n;
        n = 0;
        instr_valid <= 1'b1;
        instr_word <= w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (instr_ready_q !== 1'b1 && n < 20);
        if (instr_ready_q !== 1'b1) begin
            failures++;
            complete_run();
        end else if (last) begin
            instr_valid <= 1'b0;
        end
    endtask

    task automatic t_regs();
        rchk(REG_CTRL, 32'h1);
        rchk(REG_BANK, 32'h0);
        rchk(REG_PTR2, 32'h0);
        rchk(REG_STACK, 32'h0);
        rchk(REG_STATUS, 32'h1);
        rchk(8'h1c, 32'h0);
    endtask

    task automatic t_push();
        wr(REG_PTR2, 32'h1ec);
        send(16'hfa08, 1'b1);
        @(posedge sys_clk);
        `chk(mem_wr_en_q, 1'b1)
        `chk(mem_wr_addr_q, 12'h1ec)
        `chk(mem_wdata_q, 8'h08)
        rchk(REG_PTR2, 32'h1eb);
        wr(REG_PTR2, 32'h0);
        send(16'hfaff, 1'b1);
        @(posedge sys_clk);
        rchk(REG_PTR2, 32'hfff);
    endtask

    task automatic t_sub_pointer();
        for (int s = 0; s < 3; s++) begin
            wr(REG_PTR0 + 8'(4 * s), 32'h3ff);
            send({8'he9, 2'(s), 6'h23}, 1'b1);
            @(posedge sys_clk);
            rchk(REG_PTR0 + 8'(4 * s), 32'h3dc);
        end
    endtask

    task automatic t_return();
        wr(REG_PTR2, 32'h3ff);
        wr(REG_STACK, 32'h12345);
        send(16'he9e3, 1'b1);
        @(posedge sys_clk);
        `chk(pc_load_q, 1'b1)
        `chk(pc_value_q, 21'h12345)
        `chk(instr_ready_q, 1'b0)
        @(posedge sys_clk);
        `chk(pc_load_q, 1'b0)
        `chk(mem_wr_en_q, 1'b0)
        rchk(REG_PTR2, 32'h3dc);
    endtask

    // A read count below zero means it is not judged
    task automatic t_move(input logic [11:0] fp, input logic [6:0] zs, input logic [6:0] zd,
                          input logic [11:0] ra, input logic [11:0] wa, input int nrd,
                          input int nwr, input logic [7:0] wd);
        int r, w;
        logic [11:0] gra, gwa;
        logic [7:0] gwd;
        r = 0;
        w = 0;
        wr(REG_PTR2, {20'h0, fp});
        src_val = 8'ha5;
        send({9'h1d7, zs}, 1'b0);
        send({9'h1f5, zd}, 1'b1);
        repeat (5) begin
            @(posedge sys_clk);
            if (mem_rd_en_q === 1'b1) begin r++; gra = mem_rd_addr_q; end
            if (mem_wr_en_q === 1'b1) begin w++; gwa = mem_wr_addr_q; gwd = mem_wdata_q; end
        end
        if (nrd >= 0) `chk(r, nrd)
        `chk(w, nwr)
        if (r > 0 && nrd > 0) `chk(gra, ra)
        if (w > 0) begin `chk(gwa, wa) `chk(gwd, wd) end
    endtask

    task automatic opnd(input logic [15:0] w, input logic [11:0] ea, input logic off,
                        input logic tf);
        send(w, 1'b1);
        @(posedge sys_clk);
        `chk(eff_valid_q, 1'b1)
        `chk(eff_addr_q, ea)
        `chk(eff_offset_q, off)
        `chk(eff_to_file_q, tf)
    endtask

    task automatic t_offset();
        wr(REG_PTR2, 32'ha00);
        wr(REG_BANK, 32'h3);
        opnd(16'h262c, 12'ha2c, 1'b1, 1'b1);
        opnd(16'h242c, 12'ha2c, 1'b1, 1'b0);
        opnd(16'h8e0a, 12'ha0a, 1'b1, 1'b1);
        opnd(16'h265f, 12'ha5f, 1'b1, 1'b1);
        opnd(16'h2460, 12'hf60, 1'b0, 1'b0);
        opnd(16'h252c, 12'h32c, 1'b0, 1'b0);
        wr(REG_PTR2, 32'h0);
        opnd(16'h2410, 12'h010, 1'b1, 1'b0);
        opnd(16'h0610, 12'h010, 1'b1, 1'b1);
        opnd(16'h0310, 12'h310, 1'b0, 1'b1);
        wr(REG_PTR2, 32'hfc0);
        opnd(16'h2450, 12'h010, 1'b1, 1'b0);
        wr(REG_CTRL, 32'h0);
        opnd(16'h242c, 12'h02c, 1'b0, 1'b0);
        opnd(16'h252c, 12'h32c, 1'b0, 1'b0);
        send(16'hfa08, 1'b1);
        @(posedge sys_clk);
        `chk(mem_wr_en_q, 1'b0)
        wr(REG_CTRL, 32'h1);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_push();
        t_sub_pointer();
        t_return();
        t_move(12'h080, 7'h05, 7'h06, 12'h085, 12'h086, 1, 1, 8'ha5);
        t_move(12'hff0, 7'h7f, 7'h10, 12'h06f, 12'h000, 1, 1, 8'ha5);
        t_move(12'hfa0, 7'h45, 7'h06, 12'h000, 12'hfa6, 0, 1, 8'h00);
        t_move(12'hfa0, 7'h05, 7'h40, 12'h000, 12'h000, 0, 0, 8'h00);
        t_offset();
        complete_run();
    end
endmodule
